// [channel_map_pkg.sv]
package channel_map_pkg;

   // ----------------------------------------------------------------
   // Register port geometry and offsets
   // ----------------------------------------------------------------
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 16;
   localparam logic [7:0]  PART_ID_OFFSET  = 8'h07;
   localparam logic [7:0]  MAP_ZERO_OFFSET = 8'h10;

   // ----------------------------------------------------------------
   // Channel map field positions and reset values
   // ----------------------------------------------------------------
   localparam int          ENABLE_BIT      = 15;
   localparam int          RESERVED_HI_BIT = 14;
   localparam int          SETUP_MSB       = 13;
   localparam int          SETUP_LSB       = 12;
   localparam int          RESERVED_MSB    = 11;
   localparam int          RESERVED_LSB    = 10;
   localparam int          POS_MSB         = 9;
   localparam int          POS_LSB         = 5;
   localparam int          NEG_MSB         = 4;
   localparam int          NEG_LSB         = 0;
   localparam logic [15:0] MAP_ZERO_RESET  = 16'h8001;

   // ----------------------------------------------------------------
   // Channels and setups
   // ----------------------------------------------------------------
   localparam int          NUM_CHANNELS    = 4;
   localparam int          CHAN_W          = 2;
   localparam int          NUM_SETUPS      = 4;

   // ----------------------------------------------------------------
   // Input selector codes
   // ----------------------------------------------------------------
   localparam logic [4:0]  analog_input_zero  = 5'h00;
   localparam logic [4:0]  analog_input_one   = 5'h01;
   localparam logic [4:0]  analog_input_two   = 5'h02;
   localparam logic [4:0]  analog_input_three = 5'h03;
   localparam logic [4:0]  analog_input_four  = 5'h04;
   localparam logic [4:0]  REFERENCE_POS      = 5'h15;
   localparam logic [4:0]  REFERENCE_NEG      = 5'h16;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       enable;
      logic [1:0] setup_select;
      logic [4:0] positive_input_select;
      logic [4:0] negative_input_select;
   } chan_cfg_t;

   typedef struct packed {
      logic [1:0] channel;
      logic [1:0] setup_select;
      logic [4:0] positive_input_select;
      logic [4:0] negative_input_select;
   } conv_cfg_t;

   typedef enum logic [1:0] {
      SEQ_IDLE    = 2'b00,
      SEQ_START   = 2'b01,
      SEQ_CONVERT = 2'b11
   } seq_state_t;

   localparam chan_cfg_t MAP_ZERO_RESET_CFG = '{
      enable:                MAP_ZERO_RESET[ENABLE_BIT],
      setup_select:          MAP_ZERO_RESET[SETUP_MSB:SETUP_LSB],
      positive_input_select: MAP_ZERO_RESET[POS_MSB:POS_LSB],
      negative_input_select: MAP_ZERO_RESET[NEG_MSB:NEG_LSB]
   };

endpackage : channel_map_pkg

// [channel_round_robin.sv]
module channel_round_robin (
   input  wire logic [3:0] enable_mask_i,
   input  wire logic [1:0] current_channel_i,
   output logic      [1:0] next_channel_o,
   output logic            any_enabled_o
);

   // ----------------------------------------------------------------
   // Rotated view of the enables, starting just after the current one
   // ----------------------------------------------------------------
   logic [3:0] hit;
   logic [1:0] cand [4];

   for (genvar k = 0; k < channel_map_pkg::NUM_CHANNELS; k++) begin : g_rot
      assign cand[k] = current_channel_i + 2'(k + 1);
      assign hit[k]  = enable_mask_i[cand[k]];
   end

   // ----------------------------------------------------------------
   // The nearest enabled channel wins; the current one comes last.
   // ----------------------------------------------------------------
   always_comb begin
      next_channel_o = current_channel_i;
      if (hit[0]) begin
         next_channel_o = cand[0];
      end else if (hit[1]) begin
         next_channel_o = cand[1];
      end else if (hit[2]) begin
         next_channel_o = cand[2];
      end else if (hit[3]) begin
         next_channel_o = cand[3];
      end
      any_enabled_o = |enable_mask_i;
   end

endmodule : channel_round_robin

// [channel_map_id_regs.sv]
// Summary of operation
// [RULE1] Read-only part code at 0x07, sixteen bits, writes ignored.
// [RULE2] Channel zero map register at 0x10, sixteen bits, resets to 0x8001.
// [RULE3] Bit 15 enables channel zero; it resets to one.
// [RULE4] Several enabled channels are converted in turn without host help.
// [RULE5] Bits 13:12 pick one of four setups; reset picks setup zero.
// [RULE6] A conversion applies the four-register group of its selected setup.
// [RULE7] Host writes one selector everywhere to share a setup, else mixes.
// [RULE8] Bits 14 and 11:10 read as zero; host writes zero there.
// [RULE9] Bits 9:5 route the positive converter input; reset picks input zero.
// [RULE10] Bits 4:0 route the negative input; reset picks input one.
// [RULE11] Writable fields read back the last write or the reset value.
// [RULE12] Map changes apply from the next conversion, never mid-conversion.
module channel_map_id_regs #(
   parameter logic [15:0] PART_ID = 16'h5a3c  // Arbitrary value.
) (
   input  wire logic                                  clk_i,
   input  wire logic                                  reset_n_i,
   input  wire logic                                  ce_i,
   input  wire logic [7:0]                            address_i,
   input  wire logic [15:0]                           write_data_i,
   input  wire logic                                  write_strobe_i,
   input  wire logic                                  read_strobe_i,
   output logic      [15:0]                           read_data_o,
   input  wire channel_map_pkg::chan_cfg_t [2:0]      other_channel_cfg_i,
   input  wire logic                                  conversion_done_i,
   output logic                                       conversion_start_o,
   output logic                                       converting_o,
   output logic      [1:0]                            active_channel_o,
   output logic      [1:0]                            active_setup_o,
   output logic      [4:0]                            positive_input_o,
   output logic      [4:0]                            negative_input_o,
   output logic                                       channel_zero_enable_o
);

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   // The asynchronous reset is released through two flip-flops so that
   // every register leaves reset on the same clock edge.
   logic [1:0] reset_pipe;
   logic       rst_n;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reset_pipe <= 2'b00;
      end else begin
         reset_pipe <= {reset_pipe[0], 1'b1};
      end
   end

   assign rst_n = reset_pipe[1];

   // ----------------------------------------------------------------
   // State of the block
   // ----------------------------------------------------------------
   typedef struct packed {
      channel_map_pkg::chan_cfg_t  map_zero;
      logic [15:0]                 read_data;
      channel_map_pkg::seq_state_t state;
      channel_map_pkg::conv_cfg_t  active;
      logic                        start;
      logic                        converting;
      logic                        started_once;
   } state_t;

   localparam state_t STATE_RESET = '{
      map_zero:     channel_map_pkg::MAP_ZERO_RESET_CFG,
      read_data:    16'h0000,
      state:        channel_map_pkg::SEQ_IDLE,
      active:       '0,
      start:        1'b0,
      converting:   1'b0,
      started_once: 1'b0
   };

   state_t st;
   state_t next_st;

   // ----------------------------------------------------------------
   // Per-channel configuration view
   // ----------------------------------------------------------------
   channel_map_pkg::chan_cfg_t cfg [4];
   logic [3:0]                 enable_mask;
   logic [1:0]                 next_channel;
   logic                       any_enabled;
   logic [15:0]                map_zero_word;

   always_comb begin
      cfg[0] = st.map_zero;
      cfg[1] = other_channel_cfg_i[0];
      cfg[2] = other_channel_cfg_i[1];
      cfg[3] = other_channel_cfg_i[2];
   end

   for (genvar c = 0; c < channel_map_pkg::NUM_CHANNELS; c++) begin : g_en
      assign enable_mask[c] = cfg[c].enable;
   end

   // The search starts after the channel converted last, so that each
   // enabled channel takes its turn.
   channel_round_robin u_round_robin (
      .enable_mask_i     (enable_mask),
      .current_channel_i (st.active.channel),
      .next_channel_o    (next_channel),
      .any_enabled_o     (any_enabled)
   );

   // Reserved bits are never stored and so always read as zero.
   always_comb begin
      map_zero_word = 16'h0000;
      map_zero_word[channel_map_pkg::ENABLE_BIT] = st.map_zero.enable;  // [RULE3]
      map_zero_word[channel_map_pkg::SETUP_MSB:channel_map_pkg::SETUP_LSB] =
         st.map_zero.setup_select;  // [RULE5]
      map_zero_word[channel_map_pkg::POS_MSB:channel_map_pkg::POS_LSB] =
         st.map_zero.positive_input_select;  // [RULE9]
      map_zero_word[channel_map_pkg::NEG_MSB:channel_map_pkg::NEG_LSB] =
         st.map_zero.negative_input_select;  // [RULE10]
   end

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      next_st       = st;
      next_st.start = 1'b0;

      // Register writes. The part code accepts no write. [RULE1]
      if (write_strobe_i) begin
         if (address_i == channel_map_pkg::MAP_ZERO_OFFSET) begin  // [RULE2]
            next_st.map_zero.enable =
               write_data_i[channel_map_pkg::ENABLE_BIT];  // [RULE3] [RULE11]
            next_st.map_zero.setup_select =
               write_data_i[channel_map_pkg::SETUP_MSB:channel_map_pkg::SETUP_LSB];  // [RULE5]
            next_st.map_zero.positive_input_select =
               write_data_i[channel_map_pkg::POS_MSB:channel_map_pkg::POS_LSB];  // [RULE9]
            next_st.map_zero.negative_input_select =
               write_data_i[channel_map_pkg::NEG_MSB:channel_map_pkg::NEG_LSB];  // [RULE10]
         end
      end

      // Register reads: data stand in the cycle after the strobe only.
      next_st.read_data = 16'h0000;
      if (read_strobe_i) begin
         if (address_i == channel_map_pkg::PART_ID_OFFSET) begin
            next_st.read_data = PART_ID;  // [RULE1]
         end else if (address_i == channel_map_pkg::MAP_ZERO_OFFSET) begin
            next_st.read_data = map_zero_word;  // [RULE8] [RULE11]
         end else begin
            next_st.read_data = 16'h0000;
         end
      end

      // Conversion sequencing.
      case (st.state)
         channel_map_pkg::SEQ_IDLE: begin
            if (any_enabled) begin
               next_st.state = channel_map_pkg::SEQ_START;
            end
         end
         channel_map_pkg::SEQ_START: begin
            // Settings are captured here and held until the conversion
            // ends, so later writes cannot disturb it.
            if (any_enabled) begin
               if (st.started_once) begin
                  next_st.active.channel = next_channel;  // [RULE4]
               end else begin
                  next_st.active.channel = enable_mask[0] ? 2'h0 : next_channel;
               end
               next_st.active.setup_select =
                  cfg[next_st.active.channel].setup_select;  // [RULE6] [RULE12]
               next_st.active.positive_input_select =
                  cfg[next_st.active.channel].positive_input_select;  // [RULE12]
               next_st.active.negative_input_select =
                  cfg[next_st.active.channel].negative_input_select;  // [RULE12]
               next_st.start        = 1'b1;
               next_st.converting   = 1'b1;
               next_st.started_once = 1'b1;
               next_st.state        = channel_map_pkg::SEQ_CONVERT;
            end else begin
               next_st.state = channel_map_pkg::SEQ_IDLE;
            end
         end
         channel_map_pkg::SEQ_CONVERT: begin
            if (conversion_done_i) begin
               next_st.converting = 1'b0;
               next_st.state      = channel_map_pkg::SEQ_IDLE;  // [RULE4]
            end
         end
         default: begin
            next_st.state      = channel_map_pkg::SEQ_IDLE;
            next_st.converting = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st <= STATE_RESET;  // [RULE2]
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign read_data_o           = st.read_data;
   assign conversion_start_o    = st.start;
   assign converting_o          = st.converting;
   assign active_channel_o      = st.active.channel;
   assign active_setup_o        = st.active.setup_select;  // [RULE6]
   assign positive_input_o      = st.active.positive_input_select;
   assign negative_input_o      = st.active.negative_input_select;
   assign channel_zero_enable_o = st.map_zero.enable;

endmodule : channel_map_id_regs

// [conv_datapath_model.sv]
// Stands in for the conversion datapath; the answer delay is set by the bench.
module conv_datapath_model (
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       conversion_start_i,
   input  wire logic [7:0] latency_i,
   output logic            conversion_done_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] remaining;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         remaining         <= 8'h00;
         conversion_done_o <= 1'b0;
      end else begin
         conversion_done_o <= (remaining == 8'h01);
         if (conversion_start_i) begin
            remaining <= latency_i;
         end else if (remaining != 8'h00) begin
            remaining <= remaining - 8'h01;
         end
      end
   end
endmodule : conv_datapath_model

// [channel_map_id_regs_props.sv]
module channel_map_id_regs_props #(
   parameter logic [15:0] PART_ID = 16'h5a3c
) (
   input wire logic                              clk_i,
   input wire logic                              reset_n_i,
   input wire logic                              ce_i,
   input wire logic [7:0]                        address_i,
   input wire logic                              read_strobe_i,
   input wire logic [15:0]                       read_data_o,
   input wire channel_map_pkg::chan_cfg_t [2:0]  other_channel_cfg_i,
   input wire logic                              conversion_done_i,
   input wire logic                              conversion_start_o,
   input wire logic                              converting_o,
   input wire logic [1:0]                        active_channel_o,
   input wire logic [1:0]                        active_setup_o,
   input wire logic [4:0]                        positive_input_o,
   input wire logic [4:0]                        negative_input_o,
   input wire logic                              channel_zero_enable_o
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   logic any_enabled;
   assign any_enabled = channel_zero_enable_o | other_channel_cfg_i[0].enable | other_channel_cfg_i[1].enable
                        | other_channel_cfg_i[2].enable;

   sequence s_done;
      converting_o && conversion_done_i && ce_i;
   endsequence

   sequence s_gap;
      (any_enabled && ce_i)[*2];
   endsequence

   a_read_window: assert property ($past(ce_i) && !$past(read_strobe_i) |-> read_data_o == 16'h0000)
      else $error("read data outside answer cycle");
   a_id_value: assert property ($past(read_strobe_i && ce_i && address_i == 8'h07)
      |-> read_data_o == PART_ID) else $error("part code wrong");
   a_reserved_zero: assert property ($past(read_strobe_i && ce_i && address_i == 8'h10)
      |-> read_data_o[14] == 1'b0 && read_data_o[11:10] == 2'b00) else $error("reserved bits not zero");
   a_unmapped_zero: assert property ($past(read_strobe_i && ce_i && address_i != 8'h07
      && address_i != 8'h10) |-> read_data_o == 16'h0000) else $error("unmapped read not zero");
   a_start_pulse: assert property (conversion_start_o && ce_i |=> !conversion_start_o)
      else $error("start longer than one cycle");
   a_start_conv: assert property (conversion_start_o |-> converting_o)
      else $error("start without converting");
   a_done_ends: assert property (s_done |=> !converting_o)
      else $error("converting stays after done");
   a_next_start: assert property (s_done ##1 s_gap |=> conversion_start_o)
      else $error("next conversion not started");
   a_active_hold: assert property (converting_o && !conversion_start_o |-> $stable(active_channel_o)
      && $stable(active_setup_o) && $stable(positive_input_o) && $stable(negative_input_o))
      else $error("active settings changed mid conversion");
endmodule : channel_map_id_regs_props

bind channel_map_id_regs channel_map_id_regs_props #(.PART_ID(PART_ID)) u_props (
   .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .address_i(address_i), .read_strobe_i(read_strobe_i),
   .read_data_o(read_data_o), .other_channel_cfg_i(other_channel_cfg_i), .conversion_done_i(conversion_done_i),
   .conversion_start_o(conversion_start_o), .converting_o(converting_o), .active_channel_o(active_channel_o),
   .active_setup_o(active_setup_o), .positive_input_o(positive_input_o), .negative_input_o(negative_input_o),
   .channel_zero_enable_o(channel_zero_enable_o));

// [tb_top.sv]
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [15:0] PART_ID = 16'h3c5a;  // Arbitrary value.
   logic        clk_i, reset_n_i, ce_i, write_strobe_i, read_strobe_i, conversion_done_i;
   logic        conversion_start_o, converting_o, channel_zero_enable_o;
   logic [7:0]  address_i, latency;
   logic [15:0] write_data_i, read_data_o;
   logic [1:0]  active_channel_o, active_setup_o;
   logic [4:0]  positive_input_o, negative_input_o;
   logic [4:0]  pos_codes [4] = '{5'h00, 5'h01, 5'h02, 5'h15};
   logic [4:0]  neg_codes [4] = '{5'h03, 5'h04, 5'h16, 5'h01};
   logic [1:0]  exp_setup [4] = '{2'h2, 2'h1, 2'h0, 2'h3};
   channel_map_pkg::chan_cfg_t [2:0] other_cfg;
   int          failures, tests_run;

   channel_map_id_regs #(.PART_ID(PART_ID)) DUT (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .address_i(address_i), .write_data_i(write_data_i),
      .write_strobe_i(write_strobe_i), .read_strobe_i(read_strobe_i), .read_data_o(read_data_o),
      .other_channel_cfg_i(other_cfg), .conversion_done_i(conversion_done_i),
      .conversion_start_o(conversion_start_o), .converting_o(converting_o), .active_channel_o(active_channel_o),
      .active_setup_o(active_setup_o), .positive_input_o(positive_input_o), .negative_input_o(negative_input_o),
      .channel_zero_enable_o(channel_zero_enable_o));

   conv_datapath_model u_datapath (.clk_i(clk_i), .reset_n_i(reset_n_i), .conversion_start_i(conversion_start_o),
      .latency_i(latency), .conversion_done_o(conversion_done_i));

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   // ----------------------------------------------------------------
   // Bus cycles, comparison and closing
   // ----------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic report_and_stop;
      if (failures == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      address_i      <= a;
      write_data_i   <= d;
      write_strobe_i <= 1'b1;
      @(posedge clk_i);
      write_strobe_i <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      address_i     <= a;
      read_strobe_i <= 1'b1;
      @(posedge clk_i);
      read_strobe_i <= 1'b0;
      @(posedge clk_i);
      d = read_data_o;
   endtask : rd

   task automatic wait_start;
      int n;
      for (n = 0; n < 300; n++) begin
         @(posedge clk_i);
         if (conversion_start_o === 1'b1) break;
      end
      if (n == 300) begin
         failures++;
         report_and_stop();
      end
   endtask : wait_start

   function automatic logic [1:0] succ(input logic [1:0] c);
      return (c == 2'h0) ? 2'h1 : (c == 2'h1) ? 2'h3 : 2'h0;
   endfunction : succ

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_registers;
      logic [15:0] d;
      rd(8'h10, d);
      chk(d, 16'h8001);
      rd(8'h07, d);
      chk(d, PART_ID);
      wr(8'h07, 16'hffff);
      rd(8'h07, d);
      chk(d, PART_ID);
      rd(8'h11, d);
      chk(d, 16'h0000);
      chk({15'h0, channel_zero_enable_o}, 16'h0001);
   endtask : t_registers

   task automatic t_fields;
      logic [15:0] v, d;
      for (int i = 0; i < 4; i++) begin
         v = {2'b11, 2'(i), 2'b11, pos_codes[i], neg_codes[i]};
         wr(8'h10, v);
         rd(8'h10, d);
         chk(d, v & 16'hb3ff);
      end
      wr(8'h10, 16'h8001);
   endtask : t_fields

   task automatic t_apply;
      wait_start();
      wait_start();
      chk({14'h0, active_setup_o}, 16'h0000);
      chk({11'h0, positive_input_o}, 16'h0000);
      chk({11'h0, negative_input_o}, 16'h0001);
      wr(8'h10, 16'ha044);
      chk({11'h0, positive_input_o}, 16'h0000);
      chk({15'h0, converting_o}, 16'h0001);
      wait_start();
      chk({14'h0, active_setup_o}, 16'h0002);
      chk({11'h0, positive_input_o}, 16'h0002);
      chk({11'h0, negative_input_o}, 16'h0004);
   endtask : t_apply

   task automatic t_sequence;
      logic [1:0] prev;
      other_cfg[0] <= '{1'b1, 2'h1, 5'h03, 5'h04};
      other_cfg[2] <= '{1'b1, 2'h3, 5'h15, 5'h16};
      wait_start();
      wait_start();
      prev = active_channel_o;
      repeat (4) begin
         wait_start();
         chk({14'h0, active_channel_o}, {14'h0, succ(prev)});
         chk({14'h0, active_setup_o}, {14'h0, exp_setup[succ(prev)]});
         prev = succ(prev);
      end
      wr(8'h10, 16'h2044);
      repeat (2) @(posedge clk_i);
      chk({15'h0, channel_zero_enable_o}, 16'h0000);
      repeat (4) begin
         wait_start();
         chk({15'h0, active_channel_o == 2'h0}, 16'h0000);
      end
   endtask : t_sequence

   // A write offered while the clock enable is low must leave the map as it was.
   task automatic t_clock_enable;
      logic [15:0] d;
      ce_i <= 1'b0;
      wr(8'h10, 16'h8001);
      repeat (2) @(posedge clk_i);
      chk({15'h0, channel_zero_enable_o}, 16'h0000);
      ce_i <= 1'b1;
      rd(8'h10, d);
      chk(d, 16'h2044);
   endtask : t_clock_enable

   initial begin
      failures       = 0;
      tests_run      = 0;
      reset_n_i      = 1'b0;
      ce_i           = 1'b1;
      write_strobe_i = 1'b0;
      read_strobe_i  = 1'b0;
      address_i      = 8'h00;
      write_data_i   = 16'h0000;
      other_cfg      = '0;
      latency        = 8'd20;
      repeat (10) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      t_registers();
      t_fields();
      t_apply();
      latency <= 8'd1;
      t_sequence();
      t_clock_enable();
      report_and_stop();
   end
endmodule : tb_top
